// ===== design/psb_bridge_end.sv
// bridge end of the secondary bus: initiator, target, arbiter and parking
`timescale 1ns/1ps
`include "psb_defines.svh"
module psb_bridge_end #(
  parameter logic [3:0] TGT_WAIT = `PSB_TGT_WAIT
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic req_valid_i,
  input wire logic [3:0] req_cmd_i,
  input wire logic [31:0] req_addr_i,
  input wire logic [31:0] req_data_i,
  input wire logic [3:0] req_be_n_i,
  output logic req_ready_o,
  output logic done_o,
  output logic [31:0] rdata_o,
  output logic tgt_wr_valid_o,
  output logic [31:0] tgt_wr_addr_o,
  output logic [31:0] tgt_wr_data_o,
  output logic [3:0] tgt_wr_be_n_o,
  psb_bus_if.bridge bus
);
  psb_pkg::psb_bridge_link_t l_r; // link-side state
  psb_pkg::psb_bridge_link_t l_nxt;
  psb_pkg::psb_bridge_user_t u_r; // user-side state
  psb_pkg::psb_bridge_user_t u_nxt;
  psb_pkg::psb_drive_t d; // pin drive for next link cycle
  logic lrst_s1; // reset sync, first stage
  logic lrst_s2; // reset sync, second stage
  logic xfer; // word moved at this edge
  logic bus_idle; // FRAME and IRDY both high
  logic pend; // user request waiting
  logic t_wr; // agent access is a write
  logic tpar; // drive PAR for last data phase
  logic park; // bus parked on the bridge

  // reset brought into the link domain
  always_ff @(posedge bus.pci_clock_output_zero) begin
    lrst_s1 <= reset_n_i;
    lrst_s2 <= lrst_s1;
  end

  // link side next state and pin drive
  always_comb begin
    l_nxt = l_r;
    d = '0;
    // word moves only with both ready lines low
    xfer = !bus.irdy_n && !bus.trdy_n;
    bus_idle = bus.frame_n && bus.irdy_n;
    pend = l_r.req_s2 != l_r.req_seen;
    tpar = 1'h0;
    park = 1'h0;
    // request toggle sync from user side
    l_nxt.req_s1 = u_r.req_tgl;
    l_nxt.req_s2 = l_r.req_s1;
    // arbiter: own request outranks the agent
    if (l_r.core.st == psb_pkg::st_idle && bus_idle) begin
      l_nxt.gnt_n = bus.req_n || pend;
    end
    unique case (l_r.core.st)
      psb_pkg::st_idle: begin
        if (!bus.frame_n) begin
          l_nxt.core.tcmd = bus.cbe_n;
          l_nxt.core.taddr = bus.ad;
          l_nxt.core.st = psb_pkg::st_t_addr;
        end else if (pend && l_r.gnt_n && bus_idle) begin
          // start own access from user fields
          l_nxt.req_seen = l_r.req_s2;
          l_nxt.core.cmd = u_r.cmd;
          l_nxt.core.addr = u_r.addr;
          l_nxt.core.data = u_r.data;
          l_nxt.core.be_n = u_r.be_n;
          l_nxt.core.st = psb_pkg::st_i_addr;
        end
      end
      psb_pkg::st_i_addr: begin
        l_nxt.core.st = psb_pkg::st_i_data;
      end
      psb_pkg::st_i_data: begin
        // wait here with IRDY low until transfer
        if (xfer) begin
          l_nxt.rdata = bus.ad;
          l_nxt.ack_tgl = !l_r.ack_tgl;
          l_nxt.core.st = psb_pkg::st_i_turn;
        end
      end
      psb_pkg::st_i_turn: begin
        l_nxt.core.st = psb_pkg::st_idle;
      end
      psb_pkg::st_t_addr: begin
        l_nxt.core.wait_cnt = TGT_WAIT;
        l_nxt.core.st = psb_pkg::st_t_data;
      end
      psb_pkg::st_t_data: begin
        if (l_r.core.wait_cnt != 4'h0) begin
          l_nxt.core.wait_cnt = l_r.core.wait_cnt - 4'h1;
        end
        if (xfer) begin
          if (l_r.core.tcmd[`PSB_CMD_WR_BIT]) begin
            // write word handed to user side
            l_nxt.core.tdata = bus.ad;
            l_nxt.core.tbe_n = bus.cbe_n;
            l_nxt.core.last = bus.ad;
            l_nxt.wr_tgl = !l_r.wr_tgl;
            tpar = 1'h1;
          end
          l_nxt.core.wait_cnt = TGT_WAIT;
          // FRAME high marks the final phase
          if (bus.frame_n) begin
            l_nxt.core.st = psb_pkg::st_t_turn;
          end
        end
      end
      psb_pkg::st_t_turn: begin
        l_nxt.core.st = psb_pkg::st_idle;
      end
    endcase
    t_wr = l_nxt.core.tcmd[`PSB_CMD_WR_BIT];
    // even parity over last clock's AD and C/BE
    d.par = ^{bus.ad, bus.cbe_n};
    d.frame_n = `PSB_DEASSERTED;
    d.irdy_n = `PSB_DEASSERTED;
    d.trdy_n = `PSB_DEASSERTED;
    unique case (l_nxt.core.st)
      psb_pkg::st_idle: begin
        // park only after grant was off a full clock
        park = l_nxt.gnt_n && l_r.gnt_n && bus_idle;
        if (park) begin
          d.ad = `PSB_PARK_AD;
          d.ad_oe = 1'h1;
          d.cbe_n = `PSB_PARK_CBE;
          d.cbe_oe = 1'h1;
          d.par_oe = 1'h1;
        end
      end
      psb_pkg::st_i_addr: begin
        d.frame_n = `PSB_ASSERTED;
        d.frame_oe = 1'h1;
        d.ad = l_nxt.core.addr;
        d.ad_oe = 1'h1;
        d.cbe_n = l_nxt.core.cmd;
        d.cbe_oe = 1'h1;
      end
      psb_pkg::st_i_data: begin
        // FRAME driven high one clock, then floats
        d.frame_oe = l_r.core.st == psb_pkg::st_i_addr;
        d.irdy_n = `PSB_ASSERTED;
        d.irdy_oe = 1'h1;
        // write: bridge drives data and byte enables
        if (l_nxt.core.cmd[`PSB_CMD_WR_BIT]) begin
          d.ad = l_nxt.core.data;
          d.ad_oe = 1'h1;
          d.cbe_n = l_nxt.core.be_n;
          d.cbe_oe = 1'h1;
        end
        d.par_oe = 1'h0;
      end
      psb_pkg::st_i_turn: begin
        // IRDY high one clock before floating
        d.irdy_oe = 1'h1;
      end
      psb_pkg::st_t_addr: begin
        d.par_oe = 1'h1;
        d.trdy_oe = 1'h1;
        d.cbe_n = `PSB_TGT_BE;
        d.cbe_oe = !t_wr;
      end
      psb_pkg::st_t_data: begin
        // TRDY low once the wait has run out
        d.trdy_n = l_nxt.core.wait_cnt != 4'h0;
        d.trdy_oe = 1'h1;
        d.ad = l_nxt.core.last;
        d.ad_oe = !t_wr;
        d.cbe_n = `PSB_TGT_BE;
        d.cbe_oe = !t_wr;
        // write data parity, none for reads
        d.par_oe = tpar;
      end
      psb_pkg::st_t_turn: begin
        d.trdy_oe = 1'h1;
        // parity of the final write phase
        d.par_oe = tpar;
      end
    endcase
    // PAR trails AD release by one clock
    if (l_r.core.drv.par_oe && l_r.core.drv.ad_oe && !d.ad_oe) begin
      d.par_oe = 1'h1;
    end
    l_nxt.core.drv = d;
  end

  // link side register
  always_ff @(posedge bus.pci_clock_output_zero) begin
    if (!lrst_s2) begin
      l_r <= '0;
      l_r.gnt_n <= `PSB_DEASSERTED;
    end else begin
      l_r <= l_nxt;
    end
  end

  // user side: request latch and toggle crossings
  always_comb begin
    u_nxt = u_r;
    u_nxt.done = 1'h0;
    u_nxt.wr_pulse = 1'h0;
    u_nxt.ack_s1 = l_r.ack_tgl;
    u_nxt.ack_s2 = u_r.ack_s1;
    u_nxt.wr_s1 = l_r.wr_tgl;
    u_nxt.wr_s2 = u_r.wr_s1;
    // accept a request while idle
    if (req_valid_i && !u_r.busy) begin
      u_nxt.busy = 1'h1;
      u_nxt.req_tgl = !u_r.req_tgl;
      u_nxt.cmd = req_cmd_i;
      u_nxt.addr = req_addr_i;
      u_nxt.data = req_data_i;
      u_nxt.be_n = req_be_n_i;
    end
    // completion back from the link
    if (u_r.ack_s2 != u_r.ack_seen) begin
      u_nxt.ack_seen = u_r.ack_s2;
      u_nxt.busy = 1'h0;
      u_nxt.done = 1'h1;
      u_nxt.rdata = l_r.rdata;
    end
    // agent write word arrives
    if (u_r.wr_s2 != u_r.wr_seen) begin
      u_nxt.wr_seen = u_r.wr_s2;
      u_nxt.wr_pulse = 1'h1;
      u_nxt.wr_addr = l_r.core.taddr;
      u_nxt.wr_data = l_r.core.tdata;
      u_nxt.wr_be_n = l_r.core.tbe_n;
    end
  end

  // user side register
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      u_r <= '0;
    end else begin
      u_r <= u_nxt;
    end
  end

  // outputs
  assign req_ready_o = !u_r.busy;
  assign done_o = u_r.done;
  assign rdata_o = u_r.rdata;
  assign tgt_wr_valid_o = u_r.wr_pulse;
  assign tgt_wr_addr_o = u_r.wr_addr;
  assign tgt_wr_data_o = u_r.wr_data;
  assign tgt_wr_be_n_o = u_r.wr_be_n;
  assign bus.br_drv = l_r.core.drv;
  assign bus.gnt_n = l_r.gnt_n;
endmodule

// ===== design/psb_defines.svh
// constants shared by both ends of the secondary bus
// Behaviour
// - address on AD in first FRAME clock
// - word moves when IRDY and TRDY low
// - parked idle bridge drives all AD lines
// - command on C/BE in address phase
// - writer drives byte enables, else target
// - parked idle bridge drives C/BE lines
// - PAR makes AD, C/BE, PAR even
// - bridge initiating write leaves PAR floating
// - bridge write target drives PAR after phases
// - bridge read target: address PAR only
// - PAR floats one clock after AD
// - parked idle bridge drives PAR
// - FRAME held, dropped at final data phase
// - FRAME, IRDY driven high one clock first
// - IRDY low means initiator can complete
// - IRDY stays low until phase completes
// - target drives TRDY when it can complete
`ifndef PSB_DEFINES_SVH
`define PSB_DEFINES_SVH
`define PSB_ASSERTED 1'h0
`define PSB_DEASSERTED 1'h1
`define PSB_CMD_WR_BIT 0
`define PSB_PARK_AD 32'h0000_0000
`define PSB_PARK_CBE 4'h0
`define PSB_TGT_BE 4'h0
`define PSB_FLOAT_AD 32'hFFFF_FFFF
`define PSB_FLOAT_CBE 4'hF
`define PSB_FLOAT_BIT 1'h1
`define PSB_TGT_WAIT 4'h1
`endif

// ===== design/psb_pkg.sv
// types shared by both ends of the secondary bus
package psb_pkg;
  // link phase of one end
  typedef enum logic [2:0] {
    st_idle, st_i_addr, st_i_data, st_i_turn, st_t_addr, st_t_data, st_t_turn
  } psb_state_t;
  // pin drive of one end: value and enable per pin
  typedef struct packed {
    logic [31:0] ad;
    logic ad_oe;
    logic [3:0] cbe_n;
    logic cbe_oe;
    logic par;
    logic par_oe;
    logic frame_n;
    logic frame_oe;
    logic irdy_n;
    logic irdy_oe;
    logic trdy_n;
    logic trdy_oe;
  } psb_drive_t;
  // link state common to both ends
  typedef struct packed {
    psb_state_t st;
    logic [3:0] cmd;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] be_n;
    logic [3:0] tcmd;
    logic [31:0] taddr;
    logic [31:0] tdata;
    logic [3:0] tbe_n;
    logic [31:0] last;
    logic [3:0] wait_cnt;
    psb_drive_t drv;
  } psb_core_t;
  // bridge state on the link clock
  typedef struct packed {
    psb_core_t core;
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic ack_tgl;
    logic wr_tgl;
    logic gnt_n;
    logic [31:0] rdata;
  } psb_bridge_link_t;
  // bridge state on the reference clock
  typedef struct packed {
    logic busy;
    logic req_tgl;
    logic [3:0] cmd;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] be_n;
    logic ack_s1;
    logic ack_s2;
    logic ack_seen;
    logic done;
    logic [31:0] rdata;
    logic wr_s1;
    logic wr_s2;
    logic wr_seen;
    logic wr_pulse;
    logic [31:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_be_n;
  } psb_bridge_user_t;
  // agent state, all on the link clock
  typedef struct packed {
    psb_core_t core;
    logic busy;
    logic done;
    logic wr_pulse;
    logic req_n;
    logic [31:0] rdata;
  } psb_agent_t;
endpackage

// ===== design/psb_bus_if.sv
// secondary bus wires joining the bridge end and the agent end
`timescale 1ns/1ps
`include "psb_defines.svh"
interface psb_bus_if (
  input wire logic pci_clock_output_zero
);
  psb_pkg::psb_drive_t br_drv; // bridge pin drive
  psb_pkg::psb_drive_t ag_drv; // agent pin drive
  logic gnt_n; // grant to agent, from bridge
  logic req_n; // request from agent
  logic [31:0] ad;
  logic [3:0] cbe_n;
  logic par;
  logic frame_n;
  logic irdy_n;
  logic trdy_n;
  // wire levels: the bridge end wins if enabled, then the agent end, else the pull-up
  assign ad = br_drv.ad_oe ? br_drv.ad : (ag_drv.ad_oe ? ag_drv.ad : `PSB_FLOAT_AD);
  assign cbe_n = br_drv.cbe_oe ? br_drv.cbe_n : (ag_drv.cbe_oe ? ag_drv.cbe_n : `PSB_FLOAT_CBE);
  assign par = br_drv.par_oe ? br_drv.par : (ag_drv.par_oe ? ag_drv.par : `PSB_FLOAT_BIT);
  assign frame_n = br_drv.frame_oe ? br_drv.frame_n : (ag_drv.frame_oe ? ag_drv.frame_n : `PSB_FLOAT_BIT);
  assign irdy_n = br_drv.irdy_oe ? br_drv.irdy_n : (ag_drv.irdy_oe ? ag_drv.irdy_n : `PSB_FLOAT_BIT);
  assign trdy_n = br_drv.trdy_oe ? br_drv.trdy_n : (ag_drv.trdy_oe ? ag_drv.trdy_n : `PSB_FLOAT_BIT);
  modport bridge (input pci_clock_output_zero, ad, cbe_n, par, frame_n, irdy_n, trdy_n, req_n,
                  output br_drv, gnt_n);
  modport agent (input pci_clock_output_zero, ad, cbe_n, par, frame_n, irdy_n, trdy_n, gnt_n,
                 output ag_drv, req_n);
endinterface

// ===== design/psb_agent_end.sv
// agent end of the secondary bus: initiator and target on the link clock
`timescale 1ns/1ps
`include "psb_defines.svh"
module psb_agent_end #(
  parameter logic [3:0] TGT_WAIT = `PSB_TGT_WAIT
) (
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire logic [3:0] cmd_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] data_i,
  input wire logic [3:0] be_n_i,
  output logic busy_o,
  output logic done_o,
  output logic [31:0] rdata_o,
  output logic tgt_wr_valid_o,
  output logic [31:0] tgt_wr_addr_o,
  output logic [31:0] tgt_wr_data_o,
  output logic [3:0] tgt_wr_be_n_o,
  psb_bus_if.agent bus
);
  psb_pkg::psb_agent_t a_r; // agent state
  psb_pkg::psb_agent_t a_nxt;
  psb_pkg::psb_drive_t d; // pin drive for next cycle
  logic rst_s1; // reset sync, first stage
  logic rst_s2; // reset sync, second stage
  logic xfer; // word moved at this edge
  logic t_wr; // bridge access is a write
  logic tpar; // drive PAR for last data phase

  // reset brought into the link domain
  always_ff @(posedge bus.pci_clock_output_zero) begin
    rst_s1 <= reset_n_i;
    rst_s2 <= rst_s1;
  end

  // next state and pin drive
  always_comb begin
    a_nxt = a_r;
    d = '0;
    a_nxt.done = 1'h0;
    a_nxt.wr_pulse = 1'h0;
    tpar = 1'h0;
    xfer = !bus.irdy_n && !bus.trdy_n;
    // accept a request, ask for the bus
    if (start_i && !a_r.busy) begin
      a_nxt.busy = 1'h1;
      a_nxt.req_n = `PSB_ASSERTED;
      a_nxt.core.cmd = cmd_i;
      a_nxt.core.addr = addr_i;
      a_nxt.core.data = data_i;
      a_nxt.core.be_n = be_n_i;
    end
    unique case (a_r.core.st)
      psb_pkg::st_idle: begin
        if (!bus.frame_n) begin
          a_nxt.core.tcmd = bus.cbe_n;
          a_nxt.core.taddr = bus.ad;
          a_nxt.core.st = psb_pkg::st_t_addr;
        end else if (a_r.busy && !a_r.req_n && !bus.gnt_n && bus.irdy_n) begin
          a_nxt.core.st = psb_pkg::st_i_addr;
        end
      end
      psb_pkg::st_i_addr: begin
        a_nxt.core.st = psb_pkg::st_i_data;
      end
      psb_pkg::st_i_data: begin
        if (xfer) begin
          a_nxt.rdata = bus.ad;
          a_nxt.busy = 1'h0;
          a_nxt.done = 1'h1;
          a_nxt.req_n = `PSB_DEASSERTED;
          a_nxt.core.st = psb_pkg::st_i_turn;
        end
      end
      psb_pkg::st_i_turn: begin
        a_nxt.core.st = psb_pkg::st_idle;
      end
      psb_pkg::st_t_addr: begin
        a_nxt.core.wait_cnt = TGT_WAIT;
        a_nxt.core.st = psb_pkg::st_t_data;
      end
      psb_pkg::st_t_data: begin
        if (a_r.core.wait_cnt != 4'h0) begin
          a_nxt.core.wait_cnt = a_r.core.wait_cnt - 4'h1;
        end
        if (xfer) begin
          if (a_r.core.tcmd[`PSB_CMD_WR_BIT]) begin
            a_nxt.core.tdata = bus.ad;
            a_nxt.core.tbe_n = bus.cbe_n;
            a_nxt.core.last = bus.ad;
            a_nxt.wr_pulse = 1'h1;
            tpar = 1'h1;
          end
          a_nxt.core.wait_cnt = TGT_WAIT;
          if (bus.frame_n) begin
            a_nxt.core.st = psb_pkg::st_t_turn;
          end
        end
      end
      psb_pkg::st_t_turn: begin
        a_nxt.core.st = psb_pkg::st_idle;
      end
    endcase
    t_wr = a_nxt.core.tcmd[`PSB_CMD_WR_BIT];
    d.par = ^{bus.ad, bus.cbe_n};
    d.frame_n = `PSB_DEASSERTED;
    d.irdy_n = `PSB_DEASSERTED;
    d.trdy_n = `PSB_DEASSERTED;
    unique case (a_nxt.core.st)
      psb_pkg::st_idle: begin
        d.ad_oe = 1'h0;
      end
      psb_pkg::st_i_addr: begin
        d.frame_n = `PSB_ASSERTED;
        d.frame_oe = 1'h1;
        d.ad = a_nxt.core.addr;
        d.ad_oe = 1'h1;
        d.cbe_n = a_nxt.core.cmd;
        d.cbe_oe = 1'h1;
      end
      psb_pkg::st_i_data: begin
        d.frame_oe = a_r.core.st == psb_pkg::st_i_addr;
        d.irdy_n = `PSB_ASSERTED;
        d.irdy_oe = 1'h1;
        d.ad = a_nxt.core.data;
        d.ad_oe = a_nxt.core.cmd[`PSB_CMD_WR_BIT];
        d.cbe_n = a_nxt.core.be_n;
        d.cbe_oe = a_nxt.core.cmd[`PSB_CMD_WR_BIT];
      end
      psb_pkg::st_i_turn: begin
        d.irdy_oe = 1'h1;
      end
      psb_pkg::st_t_addr: begin
        d.par_oe = 1'h1;
        d.trdy_oe = 1'h1;
        d.cbe_n = `PSB_TGT_BE;
        d.cbe_oe = !t_wr;
      end
      psb_pkg::st_t_data: begin
        d.trdy_n = a_nxt.core.wait_cnt != 4'h0;
        d.trdy_oe = 1'h1;
        d.ad = a_nxt.core.last;
        d.ad_oe = !t_wr;
        d.cbe_n = `PSB_TGT_BE;
        d.cbe_oe = !t_wr;
        d.par_oe = tpar;
      end
      psb_pkg::st_t_turn: begin
        d.trdy_oe = 1'h1;
        d.par_oe = tpar;
      end
    endcase
    a_nxt.core.drv = d;
  end

  // state register
  always_ff @(posedge bus.pci_clock_output_zero) begin
    if (!rst_s2) begin
      a_r <= '0;
      a_r.req_n <= `PSB_DEASSERTED;
    end else begin
      a_r <= a_nxt;
    end
  end

  // outputs
  assign busy_o = a_r.busy;
  assign done_o = a_r.done;
  assign rdata_o = a_r.rdata;
  assign tgt_wr_valid_o = a_r.wr_pulse;
  assign tgt_wr_addr_o = a_r.core.taddr;
  assign tgt_wr_data_o = a_r.core.tdata;
  assign tgt_wr_be_n_o = a_r.core.tbe_n;
  assign bus.ag_drv = a_r.core.drv;
  assign bus.req_n = a_r.req_n;
endmodule

// ===== verif/psb_bus_chk.sv
// protocol checker watching the secondary bus wires
`timescale 1ns/1ps
module psb_bus_chk (
  input wire logic pci_clock_output_zero, // link clock
  input wire logic reset_n_i, // reset, active low
  input wire psb_pkg::psb_drive_t br_drv, // bridge pin drive
  input wire psb_pkg::psb_drive_t ag_drv, // agent pin drive
  input wire logic gnt_n, // grant to agent
  input wire logic [31:0] ad, // resolved address/data
  input wire logic [3:0] cbe_n, // resolved command/enables
  input wire logic par, // resolved parity
  input wire logic frame_n, // resolved frame
  input wire logic irdy_n, // resolved initiator ready
  input wire logic trdy_n // resolved target ready
);
  // all checks run on the link clock
  default clocking link_cb @(posedge pci_clock_output_zero);
  endclocking
  default disable iff (!reset_n_i);
  chk_par_even: assert property ((br_drv.par_oe || ag_drv.par_oe) |-> par == ^{$past(ad), $past(cbe_n)})
    else $error("parity not even over previous bus");
  chk_addr_phase: assert property ($fell(frame_n) |-> (br_drv.ad_oe ^ ag_drv.ad_oe) && (br_drv.cbe_oe ^ ag_drv.cbe_oe))
    else $error("address phase without one driver");
  chk_last_phase: assert property ($fell(frame_n) |=> frame_n && !irdy_n)
    else $error("single phase not marked final with irdy low");
  chk_frame_turn: assert property ((br_drv.frame_oe && br_drv.frame_n) || (ag_drv.frame_oe && ag_drv.frame_n)
    |=> !br_drv.frame_oe && !ag_drv.frame_oe)
    else $error("frame driven high longer than one clock");
  chk_irdy_turn: assert property ($fell(ag_drv.irdy_oe) |-> $past(ag_drv.irdy_n) && !$past(ag_drv.irdy_n, 2))
    else $error("irdy released without one high clock");
  chk_irdy_hold: assert property (!irdy_n && trdy_n |=> !irdy_n)
    else $error("irdy dropped before transfer");
  chk_park_drive: assert property ((gnt_n && frame_n && irdy_n)[*8] |-> br_drv.ad_oe && br_drv.cbe_oe && br_drv.par_oe)
    else $error("parked bridge not driving bus");
  chk_wr_init_par: assert property (br_drv.frame_oe && !br_drv.frame_n && cbe_n[0] |=> !br_drv.par_oe [*3])
    else $error("bridge drove parity on its own write");
  chk_tgt_par: assert property ((ag_drv.frame_oe && !ag_drv.frame_n)
    || (!irdy_n && !trdy_n && br_drv.trdy_oe && ag_drv.cbe_oe) |=> br_drv.par_oe)
    else $error("bridge target parity missing");
  chk_rd_tgt_par: assert property (ag_drv.frame_oe && !ag_drv.frame_n && !cbe_n[0] |=> ##1 !br_drv.par_oe [*2])
    else $error("bridge drove parity in read data phase");
  chk_par_release: assert property ($fell(br_drv.ad_oe) && $past(br_drv.par_oe) |-> br_drv.par_oe ##1 !br_drv.par_oe)
    else $error("parity not released one clock after ad");
endmodule

// ===== verif/pci_secondary_bus_signalling_bench.sv
// self-checking bench joining the bridge end and the agent end
`timescale 1ns/1ps
module pci_secondary_bus_signalling_bench;
  logic ref_clk_i; // user clock
  logic link_clk; // link clock
  logic reset_n_i; // reset, active low
  logic br_valid, br_ready, br_done, br_wr_valid; // bridge user handshake
  logic ag_start, ag_done, ag_wr_valid, ag_busy; // agent user handshake
  logic [3:0] br_cmd, br_be_n, ag_cmd, ag_be_n, br_wr_be_n, ag_wr_be_n;
  logic [31:0] br_addr, br_data, ag_addr, ag_data, br_rdata, ag_rdata;
  logic [31:0] br_wr_addr, br_wr_data, ag_wr_addr, ag_wr_data;
  int n_errors; // mismatches
  int checks; // comparisons made
  logic [67:0] br_got_q[$]; // words received by the bridge
  logic [67:0] ag_got_q[$]; // words received by the agent
  logic [35:0] aph_q[$]; // address phases seen on the wire
  logic [31:0] br_last, ag_last; // model: last word written to each target
  logic prev_frame_n; // frame one clock ago
  logic [35:0] prev_bus; // ad and cbe one clock ago
  psb_bus_if psb_bus_if_inst (.pci_clock_output_zero(link_clk));
  psb_bridge_end #(.TGT_WAIT(4'h0)) psb_bridge_end_inst (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .req_valid_i(br_valid), .req_cmd_i(br_cmd), .req_addr_i(br_addr), .req_data_i(br_data),
    .req_be_n_i(br_be_n), .req_ready_o(br_ready), .done_o(br_done), .rdata_o(br_rdata),
    .tgt_wr_valid_o(br_wr_valid), .tgt_wr_addr_o(br_wr_addr), .tgt_wr_data_o(br_wr_data),
    .tgt_wr_be_n_o(br_wr_be_n), .bus(psb_bus_if_inst));
  psb_agent_end #(.TGT_WAIT(4'h2)) psb_agent_end_inst (.reset_n_i(reset_n_i), .start_i(ag_start),
    .cmd_i(ag_cmd), .addr_i(ag_addr), .data_i(ag_data), .be_n_i(ag_be_n), .busy_o(ag_busy), .done_o(ag_done),
    .rdata_o(ag_rdata), .tgt_wr_valid_o(ag_wr_valid), .tgt_wr_addr_o(ag_wr_addr),
    .tgt_wr_data_o(ag_wr_data), .tgt_wr_be_n_o(ag_wr_be_n), .bus(psb_bus_if_inst));
  psb_bus_chk psb_bus_chk_inst (.pci_clock_output_zero(link_clk), .reset_n_i(reset_n_i),
    .br_drv(psb_bus_if_inst.br_drv), .ag_drv(psb_bus_if_inst.ag_drv), .gnt_n(psb_bus_if_inst.gnt_n),
    .ad(psb_bus_if_inst.ad), .cbe_n(psb_bus_if_inst.cbe_n), .par(psb_bus_if_inst.par),
    .frame_n(psb_bus_if_inst.frame_n), .irdy_n(psb_bus_if_inst.irdy_n), .trdy_n(psb_bus_if_inst.trdy_n));
  // clocks: 10 ns user, 15 ns link at an odd phase
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    link_clk = 1'b0;
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end
  // one comparison, counted and reported
  task automatic cmp(input logic [67:0] got, input logic [67:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // verdict and end of run
  task automatic give_verdict();
    if (n_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // capture words the bridge takes as target
  always @(posedge ref_clk_i) begin
    if (br_wr_valid === 1'b1) begin
      br_got_q.push_back({br_wr_addr, br_wr_data, br_wr_be_n});
    end
  end
  // wire monitor: target words, address phases, parity
  always @(posedge link_clk) begin
    if (ag_wr_valid === 1'b1) begin
      ag_got_q.push_back({ag_wr_addr, ag_wr_data, ag_wr_be_n});
    end
    if (prev_frame_n === 1'b1 && psb_bus_if_inst.frame_n === 1'b0) begin
      aph_q.push_back({psb_bus_if_inst.ad, psb_bus_if_inst.cbe_n});
    end
    if (psb_bus_if_inst.br_drv.par_oe === 1'b1 || psb_bus_if_inst.ag_drv.par_oe === 1'b1) begin
      cmp({67'h0, psb_bus_if_inst.par}, {67'h0, ^prev_bus});
    end
    prev_frame_n <= psb_bus_if_inst.frame_n;
    prev_bus <= {psb_bus_if_inst.ad, psb_bus_if_inst.cbe_n};
  end
  // one access started by either end, checked against the model
  task automatic op(input bit by_br, input logic [3:0] cmd, input bit chk_aph);
    logic [31:0] a;
    logic [31:0] d;
    logic [3:0] b;
    logic [31:0] rd;
    logic [67:0] got;
    bit seen;
    a = $urandom;
    d = $urandom;
    b = 4'($urandom);
    seen = 1'b0;
    if (by_br) begin
      @(posedge ref_clk_i);
      cmp({67'h0, br_ready}, 68'h1);
      br_valid <= 1'b1;
      br_cmd <= cmd;
      br_addr <= a;
      br_data <= d;
      br_be_n <= b;
      @(posedge ref_clk_i);
      br_valid <= 1'b0;
      // request taken: ready low while the access runs
      @(negedge ref_clk_i);
      cmp({67'h0, br_ready}, 68'h0);
    end else begin
      @(posedge link_clk);
      cmp({67'h0, ag_busy}, 68'h0);
      ag_start <= 1'b1;
      ag_cmd <= cmd;
      ag_addr <= a;
      ag_data <= d;
      ag_be_n <= b;
      @(posedge link_clk);
      ag_start <= 1'b0;
      // request taken: busy while the access runs
      @(negedge link_clk);
      cmp({67'h0, ag_busy}, 68'h1);
    end
    // bounded wait for completion
    for (int i = 0; i < 500 && !seen; i++) begin
      if (by_br) begin
        @(negedge ref_clk_i);
      end else begin
        @(negedge link_clk);
      end
      seen = by_br ? (br_done === 1'b1) : (ag_done === 1'b1);
    end
    cmp({67'h0, seen}, 68'h1);
    // free again in the cycle that reports completion
    cmp({67'h0, by_br ? br_ready : ~ag_busy}, 68'h1);
    if (!seen) begin
      give_verdict();
    end else begin
      rd = by_br ? br_rdata : ag_rdata;
      repeat (20) @(posedge ref_clk_i);
      if (chk_aph) begin
        cmp({32'h0, aph_q.pop_front()}, {32'h0, a, cmd});
      end
      if (cmd[0]) begin
        got = by_br ? ag_got_q.pop_front() : br_got_q.pop_front();
        cmp(got, {a, d, b});
        if (by_br) begin
          ag_last = d;
        end else begin
          br_last = d;
        end
      end else begin
        cmp({36'h0, rd}, {36'h0, by_br ? ag_last : br_last});
        cmp(68'(ag_got_q.size() + br_got_q.size()), 68'h0);
      end
    end
  endtask
  // main sequence
  initial begin
    reset_n_i = 1'b0;
    {br_valid, br_cmd, br_addr, br_data, br_be_n} = '0;
    {ag_start, ag_cmd, ag_addr, ag_data, ag_be_n} = '0;
    {n_errors, checks, br_last, ag_last, prev_bus} = '0;
    prev_frame_n = 1'b1;
    void'($urandom(42));
    repeat (10) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    repeat (20) @(posedge link_clk);
    // parked idle bus shows fixed levels
    if (psb_bus_if_inst.gnt_n === 1'b1) begin
      cmp({31'h0, psb_bus_if_inst.ad, psb_bus_if_inst.cbe_n, psb_bus_if_inst.par}, 68'h0);
    end
    // read before any write returns the reset word
    op(1'b1, 4'h6, 1'b1);
    // every command code from each end
    for (int i = 0; i < 32; i++) begin
      op(i[0], i[4:1], 1'b1);
    end
    // both ends request at once
    fork
      op(1'b1, 4'h7, 1'b0);
      op(1'b0, 4'hB, 1'b0);
    join
    give_verdict();
  end
endmodule
